/* e1lt_consts.svh */
// Constants of the E1 line terminal block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef E1LT_CONSTS_SVH
`define E1LT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (low byte of the AHB address)
// ----------------------------------------------------------------------
`define E1LT_OFS_CTRL 8'h00
`define E1LT_OFS_STATUS 8'h04
`define E1LT_OFS_MASK 8'h08
`define E1LT_OFS_LIVE 8'h0c

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define E1LT_CTRL_HDB3 0
`define E1LT_CTRL_SINGLE 1
`define E1LT_CTRL_RZ 2
`define E1LT_CTRL_JA_LO 3
`define E1LT_CTRL_JA_HI 4
`define E1LT_JA_OFF 2'h0
`define E1LT_JA_TX 2'h1
`define E1LT_JA_RX 2'h2
`define E1LT_ST_LOS_ON 0
`define E1LT_ST_LOS_OFF 1
`define E1LT_ST_CV 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define E1LT_CTRL_RST 5'h01
`define E1LT_MASK_RST 3'h0

// ----------------------------------------------------------------------
// Timing: clock and line rates in kHz, pulse width in ns
// ----------------------------------------------------------------------
`define E1LT_CLK_KHZ 50000
`define E1LT_LINE_KHZ 2048
`define E1LT_BIT_CYCLES (`E1LT_CLK_KHZ / `E1LT_LINE_KHZ)
`define E1LT_CLK_NS 20
`define E1LT_PULSE_NS 244
`define E1LT_PULSE_CYCLES ((`E1LT_PULSE_NS + `E1LT_CLK_NS - 1) / `E1LT_CLK_NS)
`define E1LT_LOS_ZEROS 32

`endif

/* e1lt_pkg.sv */
// Types shared by the E1 line terminal design files.
// Assumes nothing of its surroundings.
package e1lt_pkg;
  // Transmit line pulse generator states
  typedef enum logic [1:0] {TX_IDLE, TX_PLUS, TX_MINUS} e1lt_tx_state_type;
  // Jitter attenuator placement code
  typedef logic [1:0] e1lt_ja_type;
endpackage

/* e1lt_hdb3_dec.sv */
// HDB3 decoder working on one recovered bit per strobe.
// Assumes strobes at the bit rate and one mark polarity per bit at most.
`timescale 1ns/1ps
`default_nettype none
module e1lt_hdb3_dec
(
  // Clock and asynchronous reset copy
  input wire logic clk,
  input wire logic rst_n,
  // Undecoded bit in
  input wire logic bitStb,
  input wire logic inPlus,
  input wire logic inMinus,
  // Decoded bit out, four bits later
  output logic outStb,
  output logic outPlus,
  output logic outMinus,
  output logic violation
);
  import e1lt_pkg::*;

  logic [3:0] stgP, stgN, stgV, next_stgP, next_stgN, next_stgV;
  logic lastNeg, next_lastNeg;
  logic next_outStb, next_outPlus, next_outMinus, next_violation;
  logic mark, isV;

  // ----------------------------------------------------------------------
  // Four-bit window: a violation after two empty slots wipes itself and the three bits before it
  // ----------------------------------------------------------------------
  always_comb
  begin
    mark = inPlus | inMinus;
    isV = mark & (inMinus == lastNeg);
    next_stgP = stgP;
    next_stgN = stgN;
    next_stgV = stgV;
    next_lastNeg = lastNeg;
    next_outStb = bitStb;
    next_outPlus = outPlus;
    next_outMinus = outMinus;
    next_violation = violation;
    if (bitStb)
    begin
      next_outPlus = stgP[3];
      next_outMinus = stgN[3];
      next_violation = stgV[3];
      next_stgP = {stgP[2:0], inPlus};
      next_stgN = {stgN[2:0], inMinus};
      next_stgV = {stgV[2:0], 1'b0};
      if (mark)
        next_lastNeg = inMinus;
      // 000V and B00V both show two empty slots before the violation
      if (isV && !(stgP[0] | stgN[0] | stgP[1] | stgN[1]))
      begin
        next_stgP = 4'h0;
        next_stgN = 4'h0;
        next_stgV = 4'h0;
      end
      else if (isV)
        next_stgV = {stgV[2:0], 1'b1};
    end
  end

  // Register the window; first mark is taken as positive after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stgP <= 4'h0;
      stgN <= 4'h0;
      stgV <= 4'h0;
      lastNeg <= 1'b1;
      outStb <= 1'b0;
      outPlus <= 1'b0;
      outMinus <= 1'b0;
      violation <= 1'b0;
    end
    else
    begin
      stgP <= next_stgP;
      stgN <= next_stgN;
      stgV <= next_stgV;
      lastNeg <= next_lastNeg;
      outStb <= next_outStb;
      outPlus <= next_outPlus;
      outMinus <= next_outMinus;
      violation <= next_violation;
    end
  end
endmodule // e1lt_hdb3_dec
`default_nettype wire

/* e1lt_line_term.sv */
// E1 line terminal logic: transmit rail sampling, receive recovery,
// HDB3 decode, jitter attenuator, loss of signal, AHB-Lite registers.
// Assumes pins arrive asynchronous to clk (50 MHz) and are oversampled.
`timescale 1ns/1ps
`default_nettype none
`include "e1lt_consts.svh"

// Behaviour
// - Rails captured on transmit clock falling edge
// - Plus rail one alone gives positive line mark
// - Minus rail one alone gives negative line mark
// - Positive received mark pulses plus rail output
// - Negative received mark pulses minus rail output
// - HDB3 decoder used only when selected
// - Output NRZ or RZ, dual or single rail
// - Single rail: data plus, violation minus
// - Digital PLL recovers receive bit timing
// - Jitter attenuator in transmit, receive, or bypassed
// - Loss-of-signal detector flags absent line activity
module e1lt_line_term
#(
  parameter int BIT_CYCLES = `E1LT_BIT_CYCLES,
  parameter int PULSE_CYCLES = `E1LT_PULSE_CYCLES,
  parameter int LOS_ZEROS = `E1LT_LOS_ZEROS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  // Transmit terminal side
  input wire logic tx_bit_clock,
  input wire logic tx_plus_rail_in,
  input wire logic tx_minus_rail_in,
  // Line side marks
  input wire logic line_in_a,
  input wire logic line_in_b,
  output logic line_out_a,
  output logic line_out_b,
  // Receive terminal side
  output logic rx_plus_rail_out,
  output logic rx_minus_rail_out,
  output logic code_violation_flag,
  output logic signal_absent_flag
);
  import e1lt_pkg::*;

  localparam logic [5:0] BIT_LAST = 6'(BIT_CYCLES - 1);
  localparam logic [5:0] MID = 6'(BIT_CYCLES / 2);
  localparam logic [5:0] PULSE_LAST = 6'(PULSE_CYCLES - 1);
  localparam logic [7:0] LOS_LAST = 8'(LOS_ZEROS - 1);

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rstPipe;
  logic rstN;
  logic [4:0] pins, s1, s2, s3, pinF, next_pinF, pinPrev;

  assign rstN = rstPipe[1];
  assign pins = {line_in_b, line_in_a, tx_minus_rail_in, tx_plus_rail_in,
                 tx_bit_clock};
  // A pin level counts once the second and third stages agree
  assign next_pinF = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & pinF);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end

  // Three stages plus the filtered copy and its previous value
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
      pinF <= 5'h00;
      pinPrev <= 5'h00;
    end
    else
    begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      pinF <= next_pinF;
      pinPrev <= pinF;
    end
  end

  // ----------------------------------------------------------------------
  // Datapath: transmit, receive recovery, jitter attenuator, outputs
  // ----------------------------------------------------------------------
  logic [4:0] ctrl;
  e1lt_ja_type jaSel;
  logic txFall, markP, markN, rxTick, jaTick, srcTick;
  logic selStb, selP, selN, selV, decStb, decP, decN, decV;
  logic txGo, goP, goN, goV, outGo;
  e1lt_tx_state_type txState, next_txState;
  logic [5:0] txCnt, next_txCnt, jaCnt, next_jaCnt, jaPer, next_jaPer;
  logic [5:0] rxPh, next_rxPh, rxCnt, next_rxCnt;
  logic [7:0] zeroCnt, next_zeroCnt;
  logic jaHP, jaHN, jaHV, next_jaHP, next_jaHN, next_jaHV;
  logic pendP, pendN, next_pendP, next_pendN;
  logic rawStb, rawP, rawN, next_rawStb, next_rawP, next_rawN;
  logic next_lineA, next_lineB, next_rxPlus, next_rxMinus, next_cv;
  logic next_los, losOn, losOff;

  assign jaSel = ctrl[`E1LT_CTRL_JA_HI:`E1LT_CTRL_JA_LO];
  assign txFall = pinPrev[0] & ~pinF[0];
  assign markP = pinF[3] & ~pinPrev[3];
  assign markN = pinF[4] & ~pinPrev[4];
  assign rxTick = (rxPh == BIT_LAST);
  assign jaTick = (jaCnt == jaPer - 6'h01);

  // Decoder sits in the path only when selected
  assign selStb = ctrl[`E1LT_CTRL_HDB3] ? decStb : rawStb;
  assign selP = ctrl[`E1LT_CTRL_HDB3] ? decP : rawP;
  assign selN = ctrl[`E1LT_CTRL_HDB3] ? decN : rawN;
  assign selV = ctrl[`E1LT_CTRL_HDB3] & decV;

  e1lt_hdb3_dec u_dec
  (
    .clk(clk),
    .rst_n(rstN),
    .bitStb(rawStb),
    .inPlus(rawP),
    .inMinus(rawN),
    .outStb(decStb),
    .outPlus(decP),
    .outMinus(decN),
    .violation(decV)
  );

  always_comb
  begin
    // Attenuator source: transmit falling edges or receive bit strobes
    srcTick = (jaSel == `E1LT_JA_TX) ? txFall :
              (jaSel == `E1LT_JA_RX) ? selStb : 1'b0;
    next_jaCnt = jaTick ? 6'h00 : jaCnt + 6'h01;
    next_jaPer = jaPer;
    // Period moves by one cycle per bit only, which smooths the jitter;
    // early bits shorten it and late ones lengthen it, so the tick
    // settles half a period away from the bits and never slips one
    if (srcTick && jaCnt < (jaPer >> 1) && jaPer > BIT_LAST)
      next_jaPer = jaPer - 6'h01;
    else if (srcTick && jaCnt >= (jaPer >> 1) && jaPer < BIT_LAST + 6'h03)
      next_jaPer = jaPer + 6'h01;
    next_jaHP = jaTick ? 1'b0 : jaHP;
    next_jaHN = jaTick ? 1'b0 : jaHN;
    next_jaHV = jaTick ? 1'b0 : jaHV;
    // Load after clear, so a bit arriving on the tick is kept
    if (srcTick)
    begin
      next_jaHP = (jaSel == `E1LT_JA_TX) ? pinF[1] : selP;
      next_jaHN = (jaSel == `E1LT_JA_TX) ? pinF[2] : selN;
      next_jaHV = (jaSel == `E1LT_JA_RX) & selV;
    end

    // Transmit pulse generator; both rails high is not a valid mark
    txGo = (jaSel == `E1LT_JA_TX) ? jaTick : txFall;
    goP = (jaSel == `E1LT_JA_TX) ? jaHP : pinF[1];
    goN = (jaSel == `E1LT_JA_TX) ? jaHN : pinF[2];
    next_txState = txState;
    next_txCnt = txCnt + 6'h01;
    if (txGo && goP && !goN)
    begin
      next_txState = TX_PLUS;
      next_txCnt = 6'h00;
    end
    else if (txGo && goN && !goP)
    begin
      next_txState = TX_MINUS;
      next_txCnt = 6'h00;
    end
    else
    begin
      case (txState)
        TX_PLUS, TX_MINUS:
          if (txCnt == PULSE_LAST)
            next_txState = TX_IDLE;
        TX_IDLE:
          next_txCnt = 6'h00;
        default:
          next_txState = TX_IDLE;
      endcase
    end
    next_lineA = (next_txState == TX_PLUS);
    next_lineB = (next_txState == TX_MINUS);

    // Receive DPLL: marks pull the bit phase toward mid-bit
    next_rxPh = rxTick ? 6'h00 : rxPh + 6'h01;
    if ((markP | markN) && !rxTick && rxPh < MID)
      next_rxPh = rxPh + 6'h02;
    else if ((markP | markN) && !rxTick && rxPh > MID)
      next_rxPh = rxPh;
    // A mark on the tick goes to the closing bit only, never twice
    next_pendP = rxTick ? 1'b0 : pendP | markP;
    next_pendN = rxTick ? 1'b0 : pendN | markN;
    next_rawStb = rxTick;
    next_rawP = rxTick ? pendP | markP : rawP;
    next_rawN = rxTick ? pendN | markN : rawN;

    // Loss of signal: a run of empty bits sets it, any mark clears it
    next_zeroCnt = zeroCnt;
    next_los = signal_absent_flag;
    if (rxTick && (pendP | markP | pendN | markN))
    begin
      next_zeroCnt = 8'h00;
      next_los = 1'b0;
    end
    else if (rxTick && zeroCnt == LOS_LAST)
      next_los = 1'b1;
    else if (rxTick)
      next_zeroCnt = zeroCnt + 8'h01;
    losOn = next_los & ~signal_absent_flag;
    losOff = ~next_los & signal_absent_flag;

    // Receive rails: NRZ holds a full bit, RZ only the first half
    outGo = (jaSel == `E1LT_JA_RX) ? jaTick : selStb;
    next_rxCnt = (rxCnt == BIT_LAST) ? rxCnt : rxCnt + 6'h01;
    next_rxPlus = rx_plus_rail_out;
    next_rxMinus = rx_minus_rail_out;
    next_cv = code_violation_flag;
    if (outGo)
    begin
      next_rxCnt = 6'h00;
      next_cv = (jaSel == `E1LT_JA_RX) ? jaHV : selV;
      if ((jaSel == `E1LT_JA_RX) ? jaHP : selP)
        next_rxPlus = 1'b1;
      else
        next_rxPlus = 1'b0;
      next_rxMinus = (jaSel == `E1LT_JA_RX) ? jaHN : selN;
      if (ctrl[`E1LT_CTRL_SINGLE])
      begin
        next_rxPlus = (jaSel == `E1LT_JA_RX) ? jaHP | jaHN : selP | selN;
        next_rxMinus = next_cv;
      end
    end
    else if (ctrl[`E1LT_CTRL_RZ] && rxCnt == MID - 6'h01)
    begin
      next_rxPlus = 1'b0;
      next_rxMinus = 1'b0;
      next_cv = 1'b0;
    end
  end

  // Register the datapath
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      txState <= TX_IDLE;
      txCnt <= 6'h00;
      jaCnt <= 6'h00;
      jaPer <= 6'(BIT_CYCLES);
      jaHP <= 1'b0;
      jaHN <= 1'b0;
      jaHV <= 1'b0;
      rxPh <= 6'h00;
      rxCnt <= 6'h00;
      zeroCnt <= 8'h00;
      pendP <= 1'b0;
      pendN <= 1'b0;
      rawStb <= 1'b0;
      rawP <= 1'b0;
      rawN <= 1'b0;
      line_out_a <= 1'b0;
      line_out_b <= 1'b0;
      rx_plus_rail_out <= 1'b0;
      rx_minus_rail_out <= 1'b0;
      code_violation_flag <= 1'b0;
      signal_absent_flag <= 1'b0;
    end
    else
    begin
      txState <= next_txState;
      txCnt <= next_txCnt;
      jaCnt <= next_jaCnt;
      jaPer <= next_jaPer;
      jaHP <= next_jaHP;
      jaHN <= next_jaHN;
      jaHV <= next_jaHV;
      rxPh <= next_rxPh;
      rxCnt <= next_rxCnt;
      zeroCnt <= next_zeroCnt;
      pendP <= next_pendP;
      pendN <= next_pendN;
      rawStb <= next_rawStb;
      rawP <= next_rawP;
      rawN <= next_rawN;
      line_out_a <= next_lineA;
      line_out_b <= next_lineB;
      rx_plus_rail_out <= next_rxPlus;
      rx_minus_rail_out <= next_rxMinus;
      code_violation_flag <= next_cv;
      signal_absent_flag <= next_los;
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite registers and interrupt
  // ----------------------------------------------------------------------
  logic [2:0] status, mask, next_status, next_mask, evt, clr;
  logic [4:0] next_ctrl;
  logic wrPend, next_wrPend, addrOk, next_irq;
  logic [7:0] wrAddr, next_wrAddr;
  logic [31:0] next_hrdata;

  always_comb
  begin
    addrOk = hsel & htrans[1] & hready;
    next_wrPend = addrOk & hwrite;
    next_wrAddr = haddr[7:0];
    next_ctrl = ctrl;
    next_mask = mask;
    clr = 3'h0;
    // Write data arrives one cycle after its address phase
    if (wrPend)
    begin
      case (wrAddr)
        `E1LT_OFS_CTRL: next_ctrl = hwdata[4:0];
        `E1LT_OFS_MASK: next_mask = hwdata[2:0];
        `E1LT_OFS_STATUS: clr = hwdata[2:0];
        default: clr = 3'h0;
      endcase
    end
    evt = 3'h0;
    evt[`E1LT_ST_LOS_ON] = losOn;
    evt[`E1LT_ST_LOS_OFF] = losOff;
    evt[`E1LT_ST_CV] = selStb & selV;
    // A new event wins over a clear in the same cycle
    next_status = (status & ~clr) | evt;
    next_irq = |(next_status & next_mask);
    next_hrdata = hrdata;
    // Read data is ready for the data phase, so no wait states
    if (addrOk && !hwrite)
    begin
      case (haddr[7:0])
        `E1LT_OFS_CTRL: next_hrdata = {27'h0, ctrl};
        `E1LT_OFS_STATUS: next_hrdata = {29'h0, status};
        `E1LT_OFS_MASK: next_hrdata = {29'h0, mask};
        `E1LT_OFS_LIVE: next_hrdata = {26'h0, jaPer[4:0], signal_absent_flag};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  // Register the bus side
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl <= `E1LT_CTRL_RST;
      mask <= `E1LT_MASK_RST;
      status <= 3'h0;
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      mask <= next_mask;
      status <= next_status;
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= next_irq;
    end
  end
endmodule // e1lt_line_term
`default_nettype wire

/* e1lt_line_term_properties.sv */
// Port checker of the E1 line terminal block.
// Assumes the bind below; sees the top module's ports only.
`timescale 1ns/1ps
`default_nettype none
module e1lt_line_term_checker
#(
  parameter int BIT_CYCLES = 24,
  parameter int PULSE_CYCLES = 13,
  parameter int LOS_ZEROS = 32
)
(
  // Clock, reset and bus handshake
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  // Line and terminal pins
  input wire logic tx_bit_clock,
  input wire logic line_in_a,
  input wire logic line_in_b,
  input wire logic line_out_a,
  input wire logic line_out_b,
  input wire logic rx_plus_rail_out,
  input wire logic code_violation_flag,
  input wire logic signal_absent_flag
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Cycle counters; sinceFall and quiet saturated so a long idle never wraps
  // ----------------------------------------------------------------
  int highRun, sinceFall, quiet;
  int next_highRun, next_sinceFall, next_quiet;
  logic prevClk, prevA, prevB;
  always_comb
  begin
    next_highRun = line_out_a ? highRun + 1 : 0;
    next_sinceFall = (prevClk && !tx_bit_clock) ? 0 : sinceFall + 1;
    next_quiet = ((line_in_a && !prevA) || (line_in_b && !prevB)) ? 0 :
      quiet + 1;
    if (next_sinceFall > 4000) next_sinceFall = 4000;
    if (next_quiet > 4000) next_quiet = 4000;
  end
  // Reset to "long ago" for the clock edge so no stale fall counts
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      highRun <= 0;
      sinceFall <= 4000;
      quiet <= 0;
      prevClk <= 1'b0;
      prevA <= 1'b0;
      prevB <= 1'b0;
    end
    else
    begin
      highRun <= next_highRun;
      sinceFall <= next_sinceFall;
      quiet <= next_quiet;
      prevClk <= tx_bit_clock;
      prevA <= line_in_a;
      prevB <= line_in_b;
    end
  end
  sequence ahb_taken;
    hsel && htrans[1] && hready;
  endsequence
  sequence cv_start;
    $rose(code_violation_flag);
  endsequence
  a_zero_wait: assert property (ahb_taken |=> hreadyout)
    else $error("bus transfer not answered at once");
  a_pulse_long: assert property ($fell(line_out_a) |->
    highRun >= PULSE_CYCLES) else $error("line mark pulse too short");
  a_marks_excl: assert property (!(line_out_a && line_out_b))
    else $error("both line marks at once");
  a_tx_cause: assert property (
    ($rose(line_out_a) || $rose(line_out_b)) |-> sinceFall <= 64)
    else $error("line mark without a bit clock fall");
  a_los_quiet: assert property ($rose(signal_absent_flag) |->
    quiet >= (LOS_ZEROS - 2) * BIT_CYCLES)
    else $error("loss of signal during activity");
  a_los_clears: assert property (signal_absent_flag &&
    ($rose(line_in_a) || $rose(line_in_b)) |-> ##[1:60] !signal_absent_flag)
    else $error("loss of signal kept after a mark");
  a_cv_one_bit: assert property (cv_start |->
    code_violation_flag[*8] ##[1:20] !code_violation_flag)
    else $error("violation flag not one bit long");
  a_rx_cause: assert property ($rose(rx_plus_rail_out) |->
    quiet <= 8 * BIT_CYCLES) else $error("receive rail without a mark");
endmodule // e1lt_line_term_checker
bind e1lt_line_term e1lt_line_term_checker #(.BIT_CYCLES(BIT_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES), .LOS_ZEROS(LOS_ZEROS))
  e1lt_line_term_checker_inst (.clk, .arst_n, .hsel, .htrans, .hready,
  .hreadyout, .tx_bit_clock, .line_in_a, .line_in_b, .line_out_a,
  .line_out_b, .rx_plus_rail_out, .code_violation_flag,
  .signal_absent_flag);
`default_nettype wire

/* e1lt_term_model.sv */
// Terminal equipment model: transmit bit clock and NRZ rails.
// Assumes the bench calls send_bit once per bit, frames apart.
`timescale 1ns/1ps
`default_nettype none
module e1lt_term_model
(
  // Transmit pins toward the block
  output logic tx_bit_clock,
  output logic tx_plus_rail_in,
  output logic tx_minus_rail_in
);
  // Clock stands high between frames
  initial
  begin
    tx_bit_clock = 1'b1;
    tx_plus_rail_in = 1'b0;
    tx_minus_rail_in = 1'b0;
  end
  // One 160 ns period per bit; the offset keeps it off the system edges
  task automatic send_bit(input logic p, input logic m);
    #7;
    tx_plus_rail_in = p;
    tx_minus_rail_in = m;
    #80 tx_bit_clock = 1'b0; // Rails held 80 ns either side of the fall
    #80 tx_bit_clock = 1'b1;
    // Past the hold time the rails no longer carry the bit
    tx_plus_rail_in = ~p;
    tx_minus_rail_in = ~m;
  endtask
endmodule // e1lt_term_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the E1 line terminal block.
// Assumes a zero-wait bus slave; loss of signal shortened to 8 bits.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LOS_ZEROS = 8;
  logic clk, arst_n, hsel, hwrite, hreadyout, hresp, irq, line_in_a;
  logic line_in_b;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic tx_bit_clock, tx_plus_rail_in, tx_minus_rail_in;
  logic line_out_a, line_out_b, rx_plus_rail_out, rx_minus_rail_out;
  logic code_violation_flag, signal_absent_flag, p, m, rzWatch;
  logic [4:0] prev = 5'h00;
  int n_fail, comparisons, seed, lastPol, s, a, r;
  int run = 0;
  int maxRun = 0;
  int rises [5] = '{default: 0};
  int base [5];
  int e [5];
  int hseq [13] = '{1, 0, 0, 0, 1, -1, -1, 0, 0, 0, 0, 0, 0};
  wire logic [4:0] obs = {code_violation_flag, rx_minus_rail_out,
    rx_plus_rail_out, line_out_b, line_out_a};

  e1lt_line_term #(.LOS_ZEROS(LOS_ZEROS)) e1lt_line_term_inst (.clk,
    .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .tx_bit_clock,
    .tx_plus_rail_in, .tx_minus_rail_in, .line_in_a, .line_in_b,
    .line_out_a, .line_out_b, .rx_plus_rail_out, .rx_minus_rail_out,
    .code_violation_flag, .signal_absent_flag);
  e1lt_term_model e1lt_term_model_inst (.tx_bit_clock, .tx_plus_rail_in,
    .tx_minus_rail_in);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Rising edges seen on the outputs; RZ width tracked on demand
  always @(posedge clk)
  begin
    for (int i = 0; i < 5; i++)
      if (obs[i] === 1'b1 && prev[i] !== 1'b1) rises[i]++;
    prev <= obs;
    run = (rx_plus_rail_out === 1'b1) ? run + 1 : 0;
    if (rzWatch && run > maxRun) maxRun = run;
  end
  // ----------------------------------------------------------------
  // Compare, bus and line tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check_word(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_count(input string what, input int exp, got);
    comparisons++;
    if (got != exp)
    begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // A stuck slave must not hang the run
  task automatic wait_ready;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ad, input int d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
    check_word("hresp", 32'h0, {31'h0, hresp});
  endtask
  // One bit slot of 24 clocks: half a slot of mark, then rest
  task automatic line_bit(input int v);
    line_in_a <= (v > 0);
    line_in_b <= (v < 0);
    if (v != 0) lastPol = v;
    repeat (12) @(posedge clk);
    line_in_a <= 1'b0;
    line_in_b <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 22;
    {arst_n, hsel, hwrite, line_in_a, line_in_b, rzWatch} = 6'h0;
    {htrans, haddr, hwdata} = 66'h0;
    n_fail = 0;
    comparisons = 0;
    lastPol = -1;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(0, 8'h00, 0);
    check_word("ctrl", 32'h1, rd);
    bus(0, 8'h10, 0);
    check_word("unmapped", 32'h0, rd);
    // Quiet line: loss of signal raises its event; masked, then cleared
    repeat (LOS_ZEROS * 24 + 60) @(posedge clk);
    check_word("los", 32'h1, {31'h0, signal_absent_flag});
    // Live view: idle attenuator period of one bit, loss level set
    bus(0, 8'h0c, 0);
    check_word("live", 32'h31, rd);
    bus(0, 8'h04, 0);
    check_word("status", 32'h1, rd);
    check_word("irq masked", 32'h0, {31'h0, irq});
    bus(1, 8'h08, 7);
    repeat (3) @(posedge clk);
    check_word("irq", 32'h1, {31'h0, irq});
    bus(1, 8'h04, 1);
    repeat (3) @(posedge clk);
    check_word("irq cleared", 32'h0, {31'h0, irq});
    // Transmit in each attenuator placement; a both-rails bit sends none
    for (int ja = 0; ja < 3; ja++)
    begin
      bus(1, 8'h00, {ja[1:0], 3'h1});
      base = rises;
      e = '{default: 0};
      for (int i = 0; i < 12; i++)
      begin
        {p, m} = (i == 0) ? 2'h3 : 2'($random(seed));
        e[0] += p & !m;
        e[1] += m & !p;
        e1lt_term_model_inst.send_bit(p, m);
        repeat (60) @(posedge clk);
      end
      check_count("plus marks", e[0], rises[0] - base[0]);
      check_count("minus marks", e[1], rises[1] - base[1]);
    end
    // Alternate marks, no decoding, attenuator in the receive path
    bus(1, 8'h00, 32'h10);
    base = rises;
    e = '{default: 0};
    for (int i = 0; i < 20; i++)
    begin
      s = (i == 0 || i == 19 || $random(seed) & 1) ? -lastPol : 0;
      e[2] += (s > 0);
      e[3] += (s < 0);
      line_bit(s);
    end
    repeat (6) line_bit(0);
    check_count("plus rail", e[2], rises[2] - base[2]);
    check_count("minus rail", e[3], rises[3] - base[3]);
    check_word("los gone", 32'h0, {31'h0, signal_absent_flag});
    bus(0, 8'h04, 0);
    check_word("los off event", 32'h2, rd & 32'h2);
    // Zero substitution, then a stray violation, decoding on
    bus(1, 8'h00, 1);
    base = rises;
    a = -lastPol;
    r = (a > 0) ? 2 : 3;
    foreach (hseq[i]) line_bit(hseq[i] * a);
    check_count("pattern rail", 1, rises[r] - base[r]);
    check_count("other rail", 1, rises[5 - r] - base[5 - r]);
    check_count("violations", 1, rises[4] - base[4]);
    bus(0, 8'h04, 0);
    check_word("cv event", 32'h4, rd & 32'h4);
    // Single rail, return to zero: violation shows on the minus pin
    bus(1, 8'h00, 7);
    base = rises;
    a = -lastPol;
    rzWatch = 1'b1;
    for (int i = 4; i < 13; i++) line_bit(hseq[i] * a);
    rzWatch = 1'b0;
    check_count("rz width", 12, maxRun);
    check_count("violation pin", 1, rises[3] - base[3]);
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
